// ### logic/rhp_pkg.sv
package rhp_pkg;
  // ==========================================================
  // Timing
  localparam int unsigned CLK_MHZ          = 125;
  localparam int unsigned LOCK_MIN_US      = 30;
  localparam int unsigned LOCK_MAX_US      = 63;
  // Both ends convert to whole cycles exactly; pick the midpoint, rounded down
  localparam int unsigned LOCK_MIN_CYC     = LOCK_MIN_US * CLK_MHZ;
  localparam int unsigned LOCK_MAX_CYC     = LOCK_MAX_US * CLK_MHZ;
  localparam int unsigned LOCK_DEF_CYC     = (LOCK_MIN_CYC + LOCK_MAX_CYC) / 2;
  localparam int unsigned LOCK_CNT_W       = 16;

  // ==========================================================
  // Widths
  localparam int unsigned ADDR_W           = 5;
  localparam int unsigned DATA_W           = 8;
  localparam int unsigned NUM_SRC          = 4;

  // ==========================================================
  // Interrupt source indices
  localparam int unsigned SRC_PERIODIC     = 0;
  localparam int unsigned SRC_ALARM        = 1;
  localparam int unsigned SRC_TIMER        = 2;
  localparam int unsigned SRC_SUPPLY_LOSS_N        = 3;

  // ==========================================================
  // Multi-function pin source
  localparam logic [1:0] MFO_IRQ           = 2'h0;
  localparam logic [1:0] MFO_OSC           = 2'h1;
  localparam logic [1:0] MFO_TIMER0        = 2'h2;

  // ==========================================================
  // Crystal select codes; zero stops the oscillator
  localparam logic [1:0] XTAL_NONE         = 2'h0;

  typedef enum logic [2:0] {
    RHP_IDLE  = 3'h1,
    RHP_READ  = 3'h2,
    RHP_WRITE = 3'h4
  } rhp_state_e;
endpackage

// ### logic/rhp_pin_if.sv
`timescale 1ns/1ns
interface rhp_pin_if;
  logic                           req;
  logic                           act_high;
  logic                           open_drain;
  logic                           out;
  logic                           oe_n;
  modport drv (input req, input act_high, input open_drain, output out, output oe_n);
  modport ctl (output req, output act_high, output open_drain, input out, input oe_n);
endinterface

// ### logic/rhp_pin_drv.sv
`timescale 1ns/1ns
module rhp_pin_drv (
  // Clock and reset
  input  wire logic ref_clk,
  input  wire logic nrst,
  // Pin
  rhp_pin_if.drv    pin
);
  logic level;
  assign level = pin.req ~^ pin.act_high;

  // ==========================================================
  // Polarity and drive style; open drain only pulls low
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      pin.out  <= 1'b0;
      pin.oe_n <= 1'b1;
    end else begin
      pin.out  <= pin.open_drain ? 1'b0 : level;
      pin.oe_n <= pin.open_drain ? level : 1'b0;
    end
  end
endmodule

// ### logic/rhp_host_port.sv
`timescale 1ns/1ns
// Notes on behaviour
// - Chip select, read and write strobes are active low enables.
// - Read runs while chip select and read strobe are both low.
// - Write runs while both low; data captured as it ends.
// - Five select lines pick the addressed location.
// - On power fail ignore host inputs, but finish a cycle in progress.
// - Supply loss low with no read or write in progress floats the data bus.
// - Lockout follows supply loss low after 30 to 63 us unless delay programmed.
// - Four interrupt categories, each with mask and status bits.
// - Interrupt pin and multi-function pin each routable from any source.
// - Multi-function pin may carry oscillator or first timer instead.
// - Both pins have programmable polarity and push-pull or open drain.
// - Interrupt pin asserts on an enabled, pending event.
// - Oscillator runs only after a valid crystal selection.
// - Page-select bit chooses which page the select lines address.
module rhp_host_port #(
  parameter int unsigned LOCK_CYC = rhp_pkg::LOCK_DEF_CYC
) (
  // Clock and reset
  input  wire logic                          ref_clk,
  input  wire logic                          nrst,
  // Host bus
  input  wire logic                          cs_n,
  input  wire logic                          rd_n,
  input  wire logic                          wr_n,
  input  wire logic [rhp_pkg::ADDR_W-1:0]    reg_select_lines,
  input  wire logic [rhp_pkg::DATA_W-1:0]    host_data_bus_in,
  output logic      [rhp_pkg::DATA_W-1:0]    host_data_bus_out,
  output logic                               host_data_bus_oe_n,
  input  wire logic                          supply_loss_n,
  // Register file side
  output logic                               wr_stb,
  output logic                               rd_stb,
  output logic      [rhp_pkg::ADDR_W:0]      acc_addr,
  output logic      [rhp_pkg::DATA_W-1:0]    wr_data,
  input  wire logic [rhp_pkg::DATA_W-1:0]    rd_data,
  output logic                               locked_out,
  // Control
  input  wire logic                          page_sel,
  input  wire logic                          lock_delay_en,
  input  wire logic [rhp_pkg::LOCK_CNT_W-1:0] lock_delay_cyc,
  input  wire logic [1:0]                    xtal_sel,
  output logic                               osc_run,
  // Interrupts
  input  wire logic [rhp_pkg::NUM_SRC-1:0]   irq_event,
  input  wire logic [rhp_pkg::NUM_SRC-1:0]   irq_mask,
  input  wire logic [rhp_pkg::NUM_SRC-1:0]   irq_clear,
  output logic      [rhp_pkg::NUM_SRC-1:0]   irq_status,
  input  wire logic [rhp_pkg::NUM_SRC-1:0]   primary_irq_pin_route,
  input  wire logic [rhp_pkg::NUM_SRC-1:0]   mfo_route,
  input  wire logic [1:0]                    mfo_src,
  input  wire logic                          osc_clk_lvl,
  input  wire logic                          timer0_out,
  input  wire logic                          primary_irq_pin_act_high,
  input  wire logic                          primary_irq_pin_open_drain,
  input  wire logic                          mfo_act_high,
  input  wire logic                          mfo_open_drain,
  output logic                               primary_irq_pin_out,
  output logic                               primary_irq_pin_oe_n,
  output logic                               multi_function_pin_out,
  output logic                               multi_function_pin_oe_n
);
  rhp_pkg::rhp_state_e state_q;
  logic [rhp_pkg::LOCK_CNT_W-1:0] lock_cnt_q;
  logic                           lock_q;
  logic [rhp_pkg::NUM_SRC-1:0]    stat_q;
  logic                           primary_irq_pin_req;
  logic                           mfo_req;

  // Host strobes only count while not locked out
  logic rd_go;
  logic wr_go;
  assign rd_go = !lock_q && !cs_n && !rd_n;
  assign wr_go = !lock_q && !cs_n && !wr_n;

  // ==========================================================
  // Lockout timer
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      lock_cnt_q <= '0;
      lock_q     <= 1'b0;
    end else if (supply_loss_n) begin
      lock_cnt_q <= '0;
      lock_q     <= 1'b0;
    end else if (!lock_q) begin
      if (lock_delay_en ? (lock_cnt_q >= lock_delay_cyc)
                        : (lock_cnt_q >= LOCK_CYC[rhp_pkg::LOCK_CNT_W-1:0])) begin
        lock_q <= 1'b1;
      end else begin
        lock_cnt_q <= lock_cnt_q + 1'b1;
      end
    end
  end

  // ==========================================================
  // Access sequencer; an open cycle runs to its end even under lockout
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      state_q  <= rhp_pkg::RHP_IDLE;
      acc_addr <= '0;
      wr_data  <= '0;
      wr_stb   <= 1'b0;
      rd_stb   <= 1'b0;
    end else begin
      wr_stb <= 1'b0;
      rd_stb <= 1'b0;
      case (state_q)
        rhp_pkg::RHP_IDLE: begin
          if (rd_go) begin
            state_q  <= rhp_pkg::RHP_READ;
            acc_addr <= {page_sel, reg_select_lines};
            rd_stb   <= 1'b1;
          end else if (wr_go) begin
            state_q  <= rhp_pkg::RHP_WRITE;
            acc_addr <= {page_sel, reg_select_lines};
          end
        end
        rhp_pkg::RHP_READ: begin
          if (cs_n || rd_n) begin
            state_q <= rhp_pkg::RHP_IDLE;
          end
        end
        rhp_pkg::RHP_WRITE: begin
          // Data is tracked while the strobe is low, so the last value wins
          wr_data <= host_data_bus_in;
          if (cs_n || wr_n) begin
            state_q <= rhp_pkg::RHP_IDLE;
            wr_stb  <= 1'b1;
          end
        end
        default: state_q <= rhp_pkg::RHP_IDLE;
      endcase
    end
  end

  // ==========================================================
  // Data bus drive; supply loss only floats it outside a read or write
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      host_data_bus_out  <= '0;
      host_data_bus_oe_n <= 1'b1;
    end else begin
      host_data_bus_out  <= rd_data;
      host_data_bus_oe_n <= !(state_q == rhp_pkg::RHP_READ && !cs_n && !rd_n);
      if (!supply_loss_n && state_q != rhp_pkg::RHP_WRITE && state_q != rhp_pkg::RHP_READ) begin
        host_data_bus_oe_n <= 1'b1;
      end
    end
  end

  // ==========================================================
  // Status, lock flag and oscillator enable
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      stat_q     <= '0;
      locked_out <= 1'b0;
      osc_run    <= 1'b0;
    end else begin
      // Set wins over clear so no event is lost
      stat_q     <= (stat_q & ~irq_clear) | irq_event;
      locked_out <= lock_q;
      osc_run    <= (xtal_sel != rhp_pkg::XTAL_NONE);
    end
  end
  assign irq_status = stat_q;

  // ==========================================================
  // Routing to the two pins
  always_comb begin
    primary_irq_pin_req = |(stat_q & irq_mask & primary_irq_pin_route);
    case (mfo_src)
      rhp_pkg::MFO_OSC:    mfo_req = osc_clk_lvl && osc_run;
      rhp_pkg::MFO_TIMER0: mfo_req = timer0_out;
      default:             mfo_req = |(stat_q & irq_mask & mfo_route);
    endcase
  end

  rhp_pin_if primary_irq_pin_if ();
  rhp_pin_if mfo_if ();
  assign primary_irq_pin_if.req        = primary_irq_pin_req;
  assign primary_irq_pin_if.act_high   = primary_irq_pin_act_high;
  assign primary_irq_pin_if.open_drain = primary_irq_pin_open_drain;
  assign mfo_if.req         = mfo_req;
  assign mfo_if.act_high    = mfo_act_high;
  assign mfo_if.open_drain  = mfo_open_drain;

  rhp_pin_drv u_primary_irq_pin_drv (
    .ref_clk (ref_clk),
    .nrst    (nrst),
    .pin     (primary_irq_pin_if.drv)
  );
  rhp_pin_drv u_mfo_drv (
    .ref_clk (ref_clk),
    .nrst    (nrst),
    .pin     (mfo_if.drv)
  );
  assign primary_irq_pin_out     = primary_irq_pin_if.out;
  assign primary_irq_pin_oe_n    = primary_irq_pin_if.oe_n;
  assign multi_function_pin_out  = mfo_if.out;
  assign multi_function_pin_oe_n = mfo_if.oe_n;
endmodule

// ### verif/rhp_reg_model.sv
`timescale 1ns/1ns
module rhp_reg_model (
  // Clock
  input  wire logic       ref_clk,
  // Access side
  input  wire logic       wr_stb,
  input  wire logic [5:0] acc_addr,
  input  wire logic [7:0] wr_data,
  output logic      [7:0] rd_data
);
  // ==========================================
  // Storage: two pages of 32 places
  logic [7:0] mem [64];
  always_ff @(posedge ref_clk) begin
    if (wr_stb) mem[acc_addr] <= wr_data;
  end
  // Unwritten places stay unknown so a stray read cannot match
  assign rd_data = mem[acc_addr];
endmodule

// ### verif/rhp_host_port_properties.sv
`timescale 1ns/1ns
module rhp_host_port_props #(
  parameter int unsigned LOCK_CYC = 20
) (
  // Clock and reset
  input wire logic       ref_clk,
  input wire logic       nrst,
  // Host bus
  input wire logic       cs_n,
  input wire logic       rd_n,
  input wire logic       wr_n,
  input wire logic [4:0] reg_select_lines,
  input wire logic [7:0] host_data_bus_out,
  input wire logic       host_data_bus_oe_n,
  input wire logic       supply_loss_n,
  // Register file side
  input wire logic       wr_stb,
  input wire logic       rd_stb,
  input wire logic [5:0] acc_addr,
  input wire logic [7:0] rd_data,
  input wire logic       locked_out,
  // Control and status
  input wire logic       page_sel,
  input wire logic       lock_delay_en,
  input wire logic [15:0] lock_delay_cyc,
  input wire logic [1:0] xtal_sel,
  input wire logic       osc_run,
  input wire logic [3:0] irq_event,
  input wire logic [3:0] irq_status
);
  // ==========================================
  // Cycles spent with supply low, saturating
  logic [15:0] lo_cnt_q;
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) lo_cnt_q <= 16'h0000;
    else if (supply_loss_n) lo_cnt_q <= 16'h0000;
    else if (lo_cnt_q != 16'hffff) lo_cnt_q <= lo_cnt_q + 16'h0001;
  end
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!nrst);
  // ==========================================
  // Properties
  rd_pulse_a: assert property (rd_stb |=> !rd_stb) else $error("read strobe too long");
  rd_start_a: assert property (rd_stb |-> $past(!cs_n && !rd_n && !locked_out))
    else $error("read started without a valid request");
  wr_end_a: assert property (wr_stb |-> $past(cs_n || wr_n)) else $error("early write");
  addr_take_a: assert property (rd_stb |-> acc_addr == $past({page_sel, reg_select_lines}))
    else $error("wrong access address");
  drive_read_a: assert property (!host_data_bus_oe_n |-> $past(!cs_n && !rd_n, 2))
    else $error("bus driven outside a read");
  bus_float_a: assert property ($past(cs_n || rd_n) && $past(cs_n || rd_n, 2)
    |-> host_data_bus_oe_n) else $error("bus not floated");
  read_data_a: assert property (!host_data_bus_oe_n |-> host_data_bus_out == $past(rd_data))
    else $error("wrong read data");
  lock_early_a: assert property ($rose(locked_out) && !lock_delay_en
    |-> lo_cnt_q >= LOCK_CYC && lo_cnt_q <= LOCK_CYC + 3) else $error("lockout off time");
  lock_late_a: assert property (lo_cnt_q == LOCK_CYC + 4 && !lock_delay_en |-> locked_out)
    else $error("lockout missing");
  lock_prog_a: assert property ($rose(locked_out) && lock_delay_en
    |-> lo_cnt_q >= lock_delay_cyc && lo_cnt_q <= lock_delay_cyc + 3)
    else $error("programmed lockout off time");
  irq_set_a: assert property (|irq_event |=> (irq_status & $past(irq_event)) == $past(irq_event))
    else $error("status not set");
  osc_gate_a: assert property (osc_run == ($past(xtal_sel) != 2'h0)) else $error("osc gate");
  rd_c: cover property (rd_stb);
  wr_c: cover property (wr_stb);
  lock_c: cover property ($rose(locked_out));
endmodule
bind rhp_host_port rhp_host_port_props #(.LOCK_CYC(LOCK_CYC)) props_u (
  .ref_clk(ref_clk), .nrst(nrst), .cs_n(cs_n), .rd_n(rd_n), .wr_n(wr_n),
  .reg_select_lines(reg_select_lines), .host_data_bus_out(host_data_bus_out),
  .host_data_bus_oe_n(host_data_bus_oe_n), .supply_loss_n(supply_loss_n), .wr_stb(wr_stb),
  .rd_stb(rd_stb), .acc_addr(acc_addr), .rd_data(rd_data), .locked_out(locked_out),
  .page_sel(page_sel), .lock_delay_en(lock_delay_en), .lock_delay_cyc(lock_delay_cyc),
  .xtal_sel(xtal_sel), .osc_run(osc_run),
  .irq_event(irq_event), .irq_status(irq_status));

// ### verif/test_rhp_host_port.sv
`timescale 1ns/1ns
module test_rhp_host_port;
  // ==========================================
  // Signals
  logic       ref_clk, nrst, cs_n, rd_n, wr_n, sl_n, pg, ah, od, oe_n;
  logic       wr_stb, rd_stb, locked_out, osc_run, ip_out, ip_oe_n;
  logic       lde, mf_out, mf_oe_n;
  logic [15:0] ldc;
  logic [4:0] sel;
  logic [7:0] hd, dbus, dout, rd_data, wr_data;
  logic [5:0] acc_addr;
  logic [1:0] xtal;
  logic [3:0] ev, mask, clr, stat;
  int         err_total, n_compared, nwr = 0;
  // Wire level of the shared data bus
  assign dbus = oe_n ? hd : dout;
  rhp_host_port #(.LOCK_CYC(20)) dut_u (
    .ref_clk(ref_clk), .nrst(nrst), .cs_n(cs_n), .rd_n(rd_n), .wr_n(wr_n),
    .reg_select_lines(sel), .host_data_bus_in(dbus), .host_data_bus_out(dout),
    .host_data_bus_oe_n(oe_n), .supply_loss_n(sl_n), .wr_stb(wr_stb), .rd_stb(rd_stb),
    .acc_addr(acc_addr), .wr_data(wr_data), .rd_data(rd_data), .locked_out(locked_out),
    .page_sel(pg), .lock_delay_en(lde), .lock_delay_cyc(ldc), .xtal_sel(xtal),
    .osc_run(osc_run), .irq_event(ev), .irq_mask(mask), .irq_clear(clr),
    .irq_status(stat), .primary_irq_pin_route(mask), .mfo_route(mask), .mfo_src(2'h0),
    .osc_clk_lvl(1'b0), .timer0_out(1'b0), .primary_irq_pin_act_high(ah), .primary_irq_pin_open_drain(od),
    .mfo_act_high(ah), .mfo_open_drain(od), .primary_irq_pin_out(ip_out),
    .primary_irq_pin_oe_n(ip_oe_n), .multi_function_pin_out(mf_out),
    .multi_function_pin_oe_n(mf_oe_n));
  rhp_reg_model mdl_u (.ref_clk(ref_clk), .wr_stb(wr_stb), .acc_addr(acc_addr),
    .wr_data(wr_data), .rd_data(rd_data));
  initial begin
    ref_clk = 0;
    forever #4 ref_clk = ~ref_clk;
  end
  always @(posedge ref_clk) if (wr_stb === 1'b1) nwr++;
  // ==========================================
  // Tasks
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_compared++;
    if (got !== exp) begin
      err_total++;
      $display("Error t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic p, input logic [4:0] a, input logic [7:0] d);
    int i;
    pg = p; sel = a; hd = d; cs_n = 0; wr_n = 0;
    repeat (3) @(negedge ref_clk);
    wr_n = 1;
    for (i = 0; i < 8 && wr_stb !== 1'b1; i++) @(negedge ref_clk);
    chk(wr_stb, 1);
    chk(acc_addr, {p, a});
    chk(wr_data, d);
    cs_n = 1;
    @(negedge ref_clk);
  endtask
  task automatic rd(input logic p, input logic [4:0] a, input logic [7:0] e, input logic pf);
    int i;
    pg = p; sel = a; cs_n = 0; rd_n = 0;
    for (i = 0; i < 8 && oe_n !== 1'b0; i++) @(negedge ref_clk);
    chk(oe_n, 0);
    @(negedge ref_clk);
    chk(dout, e);
    if (pf) begin
      // Supply drops mid-read; the open read must run on
      sl_n = 0;
      repeat (30) @(negedge ref_clk);
      chk({oe_n, dout}, {1'b0, e});
    end
    rd_n = 1; cs_n = 1;
    repeat (3) @(negedge ref_clk);
    chk(oe_n, 1);
  endtask
  task conclude;
    $display("compared %0d errors %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  initial begin
    repeat (5000) @(posedge ref_clk);
    err_total++;
    conclude();
  end
  // ==========================================
  // Tests
  initial begin
    {cs_n, rd_n, wr_n, sl_n, nrst, pg, ah, od} = 8'hf2;
    lde = 0;
    ldc = 16'h0000;
    {sel, hd, xtal, ev, mask, clr} = {5'h00, 8'h00, 2'h0, 4'h0, 4'h4, 4'h0};
    err_total = 0; n_compared = 0;
    repeat (4) @(posedge ref_clk);
    @(negedge ref_clk) nrst = 1;
    chk({oe_n, osc_run}, 2'h2);
    xtal = 2'h2;
    repeat (2) @(negedge ref_clk);
    chk(osc_run, 1);
    $display("test reset_osc done");
    wr(0, 5'h03, 8'h5a); wr(1, 5'h03, 8'ha5); wr(0, 5'h1f, 8'h3c);
    rd(0, 5'h03, 8'h5a, 0); rd(1, 5'h03, 8'ha5, 0); rd(0, 5'h1f, 8'h3c, 0);
    $display("test access done");
    ev = 4'h1; @(negedge ref_clk); ev = 4'h0;
    repeat (2) @(negedge ref_clk);
    chk({stat, ip_out, ip_oe_n, mf_out, mf_oe_n}, 8'h10);
    ev = 4'h4; @(negedge ref_clk); ev = 4'h0;
    repeat (2) @(negedge ref_clk);
    chk({stat, ip_out, ip_oe_n, mf_out, mf_oe_n}, 8'h5a);
    // Active low open drain pulls low while asserted
    ah = 0;
    od = 1;
    repeat (2) @(negedge ref_clk);
    chk({ip_out, ip_oe_n, mf_out, mf_oe_n}, 4'h0);
    clr = 4'h4; @(negedge ref_clk); clr = 4'h0;
    repeat (3) @(negedge ref_clk);
    chk({stat, ip_oe_n, mf_oe_n}, 6'h07);
    $display("test irq done");
    rd(1, 5'h03, 8'ha5, 1);
    chk(locked_out, 1);
    i_try: begin
      int n;
      n = nwr; cs_n = 0; wr_n = 0;
      repeat (4) @(negedge ref_clk);
      wr_n = 1; cs_n = 1;
      repeat (4) @(negedge ref_clk);
      chk(nwr - n, 0);
    end
    // Supply back, then a short programmed lockout delay
    sl_n = 1;
    lde = 1;
    ldc = 16'h0005;
    repeat (2) @(negedge ref_clk);
    chk(locked_out, 0);
    sl_n = 0;
    repeat (6) @(negedge ref_clk);
    chk(locked_out, 0);
    @(negedge ref_clk);
    chk(locked_out, 1);
    $display("test lockout done");
    conclude();
  end
endmodule
